// ### hw/cbcfg_top.sv
/*
  Supervision, configuration and protection logic of a four-switch
  buck-boost controller, with an APB register port.
  Assumes analog comparators deliver plain levels from outside the clock
  domain and that the resistor code arrives already digitised as 0..15.
*/
`include "cbcfg_cfg.svh"
`default_nettype none
// How it works
// - Resistor code sampled once at power-up
// - Settings held until enable or supply drop
// - Even codes spread; hiccup on codes 3,4,7,8...
// - Codes 9-16 pick 15 percent; limit per code
// - Direction latched at soft-start; then sync clock
// - Limit active lowers peak trim while over reference
// - Hiccup halts after sustained peak limiting
// - Hiccup off-time with discharge, then soft-start
// - On-time counted only after ramp finished
// - No hiccup: keep switching under peak limiting
// - Fault pin low while any fault active
// - Every fault input de-glitched before pin
// - Overtemperature stops, cooling resumes via sequencer
// - Feedback overvoltage only reported, keeps regulating
// - Feedback overvoltage masked in power-save
// - Feedback overvoltage and supply-ok masked in soft-start
// - Output overvoltage tri-states switch nodes
// - Input overvoltage disables forced switching mode
// - Feedback below supply-ok threshold pulls fault
// - Bootstrap undervoltage stops the converter
// - Soft-start discharged whenever converter disabled
module cbcfg_top
  import cbcfg_pkg::*;
#(
  parameter int unsigned HIC_ON_CYC  = `CBCFG_HIC_ON_CYC,
  parameter int unsigned HIC_OFF_CYC = `CBCFG_HIC_OFF_CYC
) (
  input  wire logic            I_CLOCK,
  input  wire logic            I_NRST,
  input  wire logic            I_PSEL,
  input  wire logic            I_PENABLE,
  input  wire logic            I_PWRITE,
  input  wire logic [7:0]      I_PADDR,
  input  wire logic [31:0]     I_PWDATA,
  output wire logic [31:0]     O_PRDATA,
  output wire logic            O_PREADY,
  output wire logic            O_PSLVERR,
  input  wire logic            I_ENABLE_UNDERVOLTAGE_INPUT,
  input  wire logic            I_VCC_OK,
  input  wire logic [3:0]      I_CFG_CODE,
  input  wire logic            I_SYNC,
  input  wire logic            I_PEAK_LIMIT,
  input  wire logic            I_AUX_OVER_REF,
  input  wire logic            I_SS_DONE,
  input  wire logic            I_POWER_SAVE_OPERATION,
  input  wire cbcfg_fault_type I_FAULTS,
  input  wire logic            I_FAULT_OPEN_DRAIN_IN,
  output wire logic            O_FAULT_OPEN_DRAIN_OUT,
  output wire logic            O_FAULT_OPEN_DRAIN_OE,
  output wire logic            O_SWITCH_EN,
  output wire logic            O_SWITCH_NODE_HIZ,
  output wire logic            O_SS_DISCHARGE,
  output wire logic            O_FORCED_SWITCHING_MODE,
  output wire logic            O_FORWARD_ONLY,
  output wire logic            O_SYNC_CLOCK_EN,
  output wire logic            O_DUAL_RANDOM_SPREAD,
  output wire logic            O_PSM_THRESH_15,
  output wire logic            O_ILIM_EN,
  output wire logic            O_ILIM_NEG,
  output wire logic [5:0]      O_PEAK_TRIM
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_NRST);

  // =====================================================================
  // Pin synchronisers
  localparam int unsigned SW = 18;
  wire  [SW-1:0]     pins_w;
  logic [SW-1:0]     meta_q;
  logic [SW-1:0]     sync_q;
  wire               s_en;
  wire               s_vcc;
  wire               s_sync;
  wire               s_peak;
  wire               s_aux;
  wire               s_ssdone;
  wire               s_psm;
  wire  [3:0]        s_code;
  cbcfg_fault_type   s_flt;
  wire               s_fpin;

  assign pins_w = {I_ENABLE_UNDERVOLTAGE_INPUT, I_VCC_OK, I_SYNC, I_PEAK_LIMIT,
                   I_AUX_OVER_REF, I_SS_DONE, I_POWER_SAVE_OPERATION, I_CFG_CODE,
                   I_FAULTS, I_FAULT_OPEN_DRAIN_IN};
  assign {s_en, s_vcc, s_sync, s_peak, s_aux, s_ssdone, s_psm, s_code,
          s_flt, s_fpin} = sync_q;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      meta_q <= 18'h00000;
      sync_q <= 18'h00000;
    end else begin
      meta_q <= pins_w;
      sync_q <= meta_q;
    end
  end

  // =====================================================================
  // APB slave: no wait states, read data captured in setup
  logic              run_q;
  logic [31:0]       prdata_q;
  wire               apb_setup_w = I_PSEL && !I_PENABLE;
  wire               apb_acc_w   = I_PSEL && I_PENABLE;
  wire               hit_ctrl_w  = I_PADDR == `CBCFG_ADDR_CTRL;
  wire               hit_stat_w  = I_PADDR == `CBCFG_ADDR_STAT;
  wire               hit_fault_w = I_PADDR == `CBCFG_ADDR_FAULT;
  wire               hit_w       = hit_ctrl_w || hit_stat_w || hit_fault_w;
  wire               ctrl_wr_w   = apb_acc_w && I_PWRITE && hit_ctrl_w;
  wire  [31:0]       ctrl_rd_w;
  wire  [31:0]       stat_rd_w;
  wire  [31:0]       fault_rd_w;
  wire  [31:0]       rd_w;

  assign rd_w = hit_ctrl_w  ? ctrl_rd_w :
                hit_stat_w  ? stat_rd_w :
                hit_fault_w ? fault_rd_w : 32'h0000_0000;
  assign O_PRDATA  = prdata_q;
  assign O_PREADY  = 1'b1;
  // Unmapped addresses answer with an error; writes to status are dropped
  assign O_PSLVERR = apb_acc_w && !hit_w;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      prdata_q <= 32'h0000_0000;
      run_q    <= `CBCFG_CTRL_RUN_RESET;
    end else begin
      if (apb_setup_w) prdata_q <= rd_w;
      if (ctrl_wr_w) run_q <= I_PWDATA[`CBCFG_CTRL_RUN_BIT];
    end
  end

  // =====================================================================
  // Configuration latch and decode
  cbcfg_state_type   state_q;
  cbcfg_state_type   state_d;
  cbcfg_setting_type cfg_q;
  cbcfg_setting_type cfg_dec_w;
  wire               power_ok_w = s_en && s_vcc;
  wire               in_read_w  = state_q == ST_READ;

  // Code index n stands for resistor code n+1
  assign cfg_dec_w.spread = s_code[0];
  assign cfg_dec_w.hiccup = s_code[1];
  assign cfg_dec_w.psm15  = s_code[3];
  assign cfg_dec_w.ilim   = s_code[2];

  // Only the read state reloads, which is reached only through power-off
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) cfg_q <= '0;
    else if (in_read_w) cfg_q <= cfg_dec_w;
  end

  // =====================================================================
  // Current-limit direction strap
  logic              seen_high_q;
  logic              dir_neg_q;
  logic              lock_q;
  wire               ss_begin_w = state_q == ST_STANDBY && state_d == ST_SOFTSTART;

  // A sync clock shows at least one high sample, so any high means positive
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      seen_high_q <= 1'b0;
      dir_neg_q   <= 1'b0;
      lock_q      <= 1'b0;
    end else if (state_q == ST_OFF) begin
      seen_high_q <= 1'b0;
      lock_q      <= 1'b0;
    end else if (!lock_q) begin
      seen_high_q <= seen_high_q || s_sync;
      if (ss_begin_w) begin
        dir_neg_q <= !(seen_high_q || s_sync);
        lock_q    <= 1'b1;
      end
    end
  end

  // =====================================================================
  // Hiccup timers
  wire               hic_on_done_w;
  wire               hic_off_done_w;
  wire               hic_count_on_w  = state_q == ST_ACTIVE && cfg_q.hiccup && s_peak;
  wire               hic_count_off_w = state_q == ST_HICCUP;

  cbcfg_hiccup #(
    .ON_CYC  (HIC_ON_CYC),
    .OFF_CYC (HIC_OFF_CYC)
  ) u_hiccup (
    .i_clock     (I_CLOCK),
    .i_nrst      (I_NRST),
    .i_clear     (!power_ok_w),
    .i_count_on  (hic_count_on_w),
    .i_count_off (hic_count_off_w),
    .o_on_done   (hic_on_done_w),
    .o_off_done  (hic_off_done_w)
  );

  // =====================================================================
  // Main sequencer
  always_comb begin
    state_d = state_q;
    if (!power_ok_w) begin
      state_d = ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: state_d = ST_READ;
        ST_READ: state_d = ST_STANDBY;
        ST_STANDBY: begin
          if (s_flt.thermal) state_d = ST_THERMAL;
          else if (run_q && !s_flt.boot_uv) state_d = ST_SOFTSTART;
        end
        ST_SOFTSTART, ST_ACTIVE: begin
          if (s_flt.thermal) state_d = ST_THERMAL;
          else if (s_flt.boot_uv || !run_q) state_d = ST_STANDBY;
          else if (state_q == ST_SOFTSTART && s_ssdone) state_d = ST_ACTIVE;
          else if (state_q == ST_ACTIVE && hic_on_done_w) state_d = ST_HICCUP;
        end
        ST_HICCUP: begin
          if (s_flt.thermal) state_d = ST_THERMAL;
          else if (hic_off_done_w) state_d = ST_STANDBY;
        end
        ST_THERMAL: if (!s_flt.thermal) state_d = ST_STANDBY;
        default: state_d = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) state_q <= ST_OFF;
    else state_q <= state_d;
  end

  // =====================================================================
  // Peak-current trim, stepped on a slow enable
  logic [5:0]        div_q;
  logic [5:0]        trim_q;
  wire               tick_w   = &div_q;
  wire               lower_w  = cfg_q.ilim && s_aux;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      div_q  <= 6'h00;
      trim_q <= `CBCFG_TRIM_MAX;
    end else begin
      div_q <= div_q + 6'h01;
      if (!cfg_q.ilim) trim_q <= `CBCFG_TRIM_MAX;
      else if (tick_w && lower_w && trim_q != 6'h00) trim_q <= trim_q - 6'h01;
      else if (tick_w && !lower_w && trim_q != `CBCFG_TRIM_MAX) trim_q <= trim_q + 6'h01;
    end
  end

  // =====================================================================
  // Fault filtering, masking and pin drive
  cbcfg_fault_type   clean_w;
  cbcfg_fault_type   masked_w;
  wire               in_ss_w = state_q == ST_SOFTSTART;
  wire               fault_any_w = |masked_w;

  cbcfg_deglitch u_deglitch (
    .i_clock (I_CLOCK),
    .i_nrst  (I_NRST),
    .i_raw   (s_flt),
    .o_clean (clean_w)
  );

  assign masked_w = {clean_w.thermal,
                     clean_w.fb_ov && !in_ss_w && !s_psm,
                     clean_w.out_ov,
                     clean_w.in_ov,
                     clean_w.boot_uv,
                     clean_w.pg_low && !in_ss_w};

  // =====================================================================
  // Registered outputs
  logic              sw_en_q;
  logic              ss_dis_q;
  logic              forced_switching_mode_q;
  logic              flt_oe_q;
  wire               run_next_w = state_d == ST_SOFTSTART || state_d == ST_ACTIVE;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      sw_en_q  <= 1'b0;
      ss_dis_q <= 1'b1;
      forced_switching_mode_q   <= 1'b0;
      flt_oe_q <= 1'b0;
    end else begin
      sw_en_q  <= run_next_w && !s_flt.out_ov;
      ss_dis_q <= !run_next_w;
      forced_switching_mode_q   <= !s_flt.in_ov;
      flt_oe_q <= fault_any_w;
    end
  end

  assign O_FAULT_OPEN_DRAIN_OUT  = 1'b0;
  assign O_FAULT_OPEN_DRAIN_OE   = flt_oe_q;
  assign O_SWITCH_EN             = sw_en_q;
  assign O_SWITCH_NODE_HIZ       = !sw_en_q;
  assign O_SS_DISCHARGE          = ss_dis_q;
  assign O_FORCED_SWITCHING_MODE = forced_switching_mode_q;
  assign O_FORWARD_ONLY          = !forced_switching_mode_q;
  assign O_SYNC_CLOCK_EN         = lock_q;
  assign O_DUAL_RANDOM_SPREAD    = cfg_q.spread;
  assign O_PSM_THRESH_15         = cfg_q.psm15;
  assign O_ILIM_EN               = cfg_q.ilim;
  assign O_ILIM_NEG              = dir_neg_q;
  assign O_PEAK_TRIM             = trim_q;

  // =====================================================================
  // Register read views
  assign ctrl_rd_w  = 32'(run_q) << `CBCFG_CTRL_RUN_BIT;
  assign stat_rd_w  = 32'(state_q) | (32'(dir_neg_q) << `CBCFG_STAT_DIRNEG_BIT)
                    | (32'(lock_q) << `CBCFG_STAT_LOCK_BIT)
                    | (32'(cfg_q) << `CBCFG_STAT_CFG_LSB)
                    | (32'(trim_q) << `CBCFG_STAT_TRIM_LSB);
  assign fault_rd_w = 32'(masked_w) | (32'(s_fpin) << `CBCFG_FAULT_PIN_BIT);

  // =====================================================================
  // Checks
  localparam int REACT_MAX = 130;

  a_cfg_stable: assert property (
    !in_read_w |=> $stable(cfg_q))
    else $error("configuration changed outside read state");

  a_cfg_decode: assert property (
    in_read_w |=> cfg_q.spread == $past(s_code[0]) && cfg_q.hiccup == $past(s_code[1]))
    else $error("spread or hiccup decode wrong");

  a_psm_ilim: assert property (
    in_read_w |=> cfg_q.psm15 == $past(s_code[3]) && cfg_q.ilim == $past(s_code[2]))
    else $error("threshold or limit decode wrong");

  a_dir_latch: assert property (
    $rose(lock_q) |-> $past(state_q) == ST_STANDBY && state_q == ST_SOFTSTART)
    else $error("direction latched outside soft-start begin");

  a_hiccup_enter: assert property (
    state_q == ST_ACTIVE && hic_on_done_w && power_ok_w && run_q
      && !s_flt.thermal && !s_flt.boot_uv |=> state_q == ST_HICCUP ##1 ss_dis_q)
    else $error("hiccup halt missed");

  a_no_hiccup: assert property (
    !cfg_q.hiccup && state_q == ST_ACTIVE |=> state_q != ST_HICCUP)
    else $error("hiccup entered while disabled");

  a_ramp_count: assert property (
    state_q == ST_SOFTSTART |=> !hic_on_done_w)
    else $error("on-time counted during ramp");

  a_therm_stop: assert property (
    state_q == ST_THERMAL |=> !sw_en_q && ss_dis_q)
    else $error("switching during thermal shutdown");

  a_out_ov_hiz: assert property (
    s_flt.out_ov |=> !O_SWITCH_EN && O_SWITCH_NODE_HIZ)
    else $error("switch nodes driven under output overvoltage");

  a_forced_switching_mode_off: assert property (
    s_flt.in_ov |=> !O_FORCED_SWITCHING_MODE ##0 O_FORWARD_ONLY)
    else $error("forced switching kept under input overvoltage");

  a_ss_mask: assert property (
    in_ss_w |-> !masked_w.fb_ov && !masked_w.pg_low)
    else $error("fault reported during soft-start");

  a_flt_react: assert property (
    $rose(s_flt.thermal) |-> ##[1:REACT_MAX] (O_FAULT_OPEN_DRAIN_OE || !s_flt.thermal))
    else $error("fault pin reaction too slow");
endmodule
`default_nettype wire

// ### common/cbcfg_cfg.svh
/*
  Timing counts, register offsets, field positions and reset values for the
  converter supervision block. Assumes a 125 MHz core clock.
*/
`ifndef CBCFG_CFG_SVH
`define CBCFG_CFG_SVH
// =====================================================================
// Timing
`define CBCFG_CLK_MHZ          125
`define CBCFG_GLITCH_NS        1000
`define CBCFG_GLITCH_CYC       ((`CBCFG_GLITCH_NS * `CBCFG_CLK_MHZ + 999) / 1000)
`define CBCFG_HIC_ON_US        20
`define CBCFG_HIC_ON_CYC       (`CBCFG_HIC_ON_US * `CBCFG_CLK_MHZ)
`define CBCFG_HIC_OFF_US       2000
`define CBCFG_HIC_OFF_CYC      (`CBCFG_HIC_OFF_US * `CBCFG_CLK_MHZ)
`define CBCFG_TRIM_MAX         6'h3f
// =====================================================================
// Register map
`define CBCFG_ADDR_CTRL        8'h00
`define CBCFG_ADDR_STAT        8'h04
`define CBCFG_ADDR_FAULT       8'h08
`define CBCFG_CTRL_RUN_BIT     0
`define CBCFG_CTRL_RUN_RESET   1'b1
`define CBCFG_STAT_DIRNEG_BIT  4
`define CBCFG_STAT_LOCK_BIT    5
`define CBCFG_STAT_CFG_LSB     8
`define CBCFG_STAT_TRIM_LSB    16
`define CBCFG_FAULT_PIN_BIT    8
`endif

// ### common/cbcfg_pkg.sv
/*
  Shared types of the converter supervision block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package cbcfg_pkg;
  // =====================================================================
  // Main sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_READ,
    ST_STANDBY,
    ST_SOFTSTART,
    ST_ACTIVE,
    ST_HICCUP,
    ST_THERMAL
  } cbcfg_state_type;

  // Decoded resistor-code settings
  typedef struct packed {
    logic spread;
    logic hiccup;
    logic psm15;
    logic ilim;
  } cbcfg_setting_type;

  // Monitored fault comparators
  typedef struct packed {
    logic thermal;
    logic fb_ov;
    logic out_ov;
    logic in_ov;
    logic boot_uv;
    logic pg_low;
  } cbcfg_fault_type;
endpackage
`default_nettype wire

// ### hw/cbcfg_deglitch.sv
/*
  Per-input de-glitch filter for the fault comparators.
  Assumes inputs are already synchronised to i_clock.
*/
`include "cbcfg_cfg.svh"
`default_nettype none
module cbcfg_deglitch
  import cbcfg_pkg::*;
(
  input  wire logic            i_clock,
  input  wire logic            i_nrst,
  input  wire cbcfg_fault_type i_raw,
  output wire cbcfg_fault_type o_clean
);
  localparam int unsigned NB   = $bits(cbcfg_fault_type);
  localparam logic [7:0]  LAST = 8'(`CBCFG_GLITCH_CYC - 1);

  wire  [NB-1:0] raw_w;
  wire  [NB-1:0] clean_w;

  assign raw_w   = i_raw;
  assign o_clean = clean_w;

  // =====================================================================
  // A level must stand for the full window before it is passed on
  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_bit
      logic [7:0] cnt_q;
      logic       held_q;
      wire        differ_w = raw_w[b] != held_q;
      assign clean_w[b] = held_q;
      always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
          cnt_q  <= 8'h00;
          held_q <= 1'b0;
        end else if (!differ_w) begin
          cnt_q  <= 8'h00;
        end else if (cnt_q == LAST) begin
          cnt_q  <= 8'h00;
          held_q <= raw_w[b];
        end else begin
          cnt_q  <= cnt_q + 8'h01;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### hw/cbcfg_hiccup.sv
/*
  Hiccup on-time and off-time counters.
  Assumes the caller drops i_count_on as soon as the overload goes away.
*/
`default_nettype none
module cbcfg_hiccup #(
  parameter int unsigned ON_CYC  = 1,
  parameter int unsigned OFF_CYC = 1
) (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  input  wire logic i_clear,
  input  wire logic i_count_on,
  input  wire logic i_count_off,
  output wire logic o_on_done,
  output wire logic o_off_done
);
  logic [17:0] on_q;
  logic [17:0] off_q;

  assign o_on_done  = on_q == 18'(ON_CYC);
  assign o_off_done = off_q == 18'(OFF_CYC - 1);

  // =====================================================================
  // Any break in the overload restarts the on-time measurement
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      on_q <= 18'h00000;
    end else if (i_clear || !i_count_on) begin
      on_q <= 18'h00000;
    end else if (!o_on_done) begin
      on_q <= on_q + 18'h00001;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      off_q <= 18'h00000;
    end else if (i_clear || !i_count_off) begin
      off_q <= 18'h00000;
    end else if (!o_off_done) begin
      off_q <= off_q + 18'h00001;
    end
  end
endmodule
`default_nettype wire

// ### sim/cbcfg_board.sv
/*
  Board model: enable pin, sync strap then sync clock, pulled-up fault net.
  Assumes the testbench sets i_neg before raising i_on.
*/
`default_nettype none
module cbcfg_board (
  input  wire logic i_clock,
  input  wire logic i_on,
  input  wire logic i_neg,
  input  wire logic i_lock,
  input  wire logic i_fault_oe,
  output var  logic o_enable,
  output var  logic o_sync,
  output wire logic o_fault_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic div_q = 1'b0;
  // Pull-up wins unless the device sinks the net
  assign o_fault_wire = i_fault_oe ? 1'b0 : 1'b1;
  initial begin
    o_enable = 1'b0;
    o_sync   = 1'b1;
  end
  always @(posedge i_clock) begin
    div_q    <= ~div_q;
    o_enable <= i_on;
    if (!i_lock) begin
      o_sync <= ~i_neg;
    end else begin
      o_sync <= div_q; // Sync clock once the strap is latched
    end
  end
endmodule
`default_nettype wire

// ### sim/tb.sv
/*
  Self-checking bench for the supervision block, APB reads checked by a monitor.
  Assumes the board model in cbcfg_board.sv.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} cbcfg_note_type;
  logic        clk, nrst, psel, pen, pwr, want, en_req, vcc, neg, sdone, plim, aux, psave;
  logic        pready, pslverr, oe, lock, fwire, en_pin, sync_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic [3:0]  code;
  logic        fout, sw_en, hiz, ssdis, forced_switching_mode, fwd, spread, psm15, ilim, ilneg;
  logic [5:0]  flt, trim;
  int          error_cnt, compares, seed, i, k;
  cbcfg_note_type notes[$];
  cbcfg_note_type nt;
  always #4 clk = ~clk;
  cbcfg_top #(.HIC_ON_CYC(8), .HIC_OFF_CYC(16)) dut_u (
    .I_CLOCK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_ENABLE_UNDERVOLTAGE_INPUT(en_pin), .I_VCC_OK(vcc),
    .I_CFG_CODE(code), .I_SYNC(sync_pin), .I_PEAK_LIMIT(plim), .I_AUX_OVER_REF(aux),
    .I_SS_DONE(sdone), .I_POWER_SAVE_OPERATION(psave), .I_FAULTS(flt),
    .I_FAULT_OPEN_DRAIN_IN(fwire), .O_FAULT_OPEN_DRAIN_OUT(fout), .O_FAULT_OPEN_DRAIN_OE(oe),
    .O_SWITCH_EN(sw_en), .O_SWITCH_NODE_HIZ(hiz), .O_SS_DISCHARGE(ssdis),
    .O_FORCED_SWITCHING_MODE(forced_switching_mode), .O_FORWARD_ONLY(fwd), .O_SYNC_CLOCK_EN(lock),
    .O_DUAL_RANDOM_SPREAD(spread), .O_PSM_THRESH_15(psm15), .O_ILIM_EN(ilim),
    .O_ILIM_NEG(ilneg), .O_PEAK_TRIM(trim));
  cbcfg_board board_u (.i_clock(clk), .i_on(en_req), .i_neg(neg), .i_lock(lock),
    .i_fault_oe(oe), .o_enable(en_pin), .o_sync(sync_pin), .o_fault_wire(fwire));
  // ====================
  // Checking
  task automatic test_done();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(posedge clk) begin
    if (psel && pen && want && notes.size() > 0) begin
      nt = notes.pop_front();
      chk("read data", prdata & nt.m, nt.d);
      chk("slave error", {31'h0, pslverr}, {31'h0, nt.e});
    end
  end
  // ====================
  // Bus and wait helpers
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic nb, output logic [31:0] rq);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    want <= nb;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 50);
    if (!pready) begin
      error_cnt++;
      test_done();
    end
    rq = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    want <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er);
    logic [31:0] rq;
    notes.push_back('{e, m, er});
    bus(1'b0, a, 32'h0, 1'b1, rq);
  endtask
  task automatic wait_st(input logic [2:0] s);
    int n;
    logic [31:0] rq;
    n = 0;
    do begin
      bus(1'b0, 8'h04, 32'h0, 1'b0, rq);
      n++;
    end while (rq[2:0] !== s && n < 200);
    if (rq[2:0] !== s) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  // ====================
  // Scenarios
  initial begin
    clk = 0; nrst = 0; psel = 0; pen = 0; pwr = 0; want = 0; paddr = 0; pwdata = 0;
    en_req = 0; vcc = 1; neg = 0; sdone = 0; plim = 0; aux = 0; psave = 0;
    code = 0; flt = 0; seed = 32'h41ce; error_cnt = 0; compares = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(8'h00, 32'h1, 32'h1, 1'b0);
    rd(8'h0c, 32'h0, 32'hffffffff, 1'b1);
    for (i = 0; i < 16; i++) begin
      code <= i[3:0];
      neg <= 1'($random(seed));
      en_req <= 1'b1;
      wait_st(3'd3);
      code <= ~i[3:0];
      tick(20);
      rd(8'h04, {20'h0, i[0], i[1], i[3], i[2], 3'b001, neg, 4'h0}, 32'hf30, 1'b0);
      chk("cfg pins", {29'h0, spread, psm15, ilim}, {29'h0, i[0], i[3], i[2]});
      chk("direction pin", {31'h0, ilneg}, {31'h0, neg});
      chk("soft-start pins", {30'h0, sw_en, ssdis}, 32'h2);
      en_req <= 1'b0;
      wait_st(3'd0);
      chk("off pins", {30'h0, sw_en, ssdis}, 32'h1);
    end
    code <= 4'h2;
    sdone <= 1'b1;
    en_req <= 1'b1;
    wait_st(3'd4);
    plim <= 1'b1;
    wait_st(3'd5);
    chk("hiccup pins", {30'h0, sw_en, ssdis}, 32'h1);
    sdone <= 1'b0;
    wait_st(3'd3);
    tick(40);
    rd(8'h04, 32'h3, 32'h7, 1'b0);
    en_req <= 1'b0;
    wait_st(3'd0);
    code <= 4'h0;
    sdone <= 1'b1;
    en_req <= 1'b1;
    wait_st(3'd4);
    tick(60);
    rd(8'h04, 32'h4, 32'h7, 1'b0);
    plim <= 1'b0;
    chk("fault drive", {31'h0, fout}, 32'h0);
    for (k = 0; k < 6; k++) begin
      flt <= 6'h1 << k;
      tick(140);
      rd(8'h08, 32'h1 << k, 32'h13f, 1'b0);
      if (k == 4) rd(8'h04, 32'h4, 32'h7, 1'b0);
      if (k == 5) rd(8'h04, 32'h6, 32'h7, 1'b0);
      if (k == 3) chk("switch pins", {30'h0, sw_en, hiz}, 32'h1);
      if (k == 2) chk("mode pins", {30'h0, forced_switching_mode, fwd}, 32'h1);
      flt <= 6'h0;
      tick(140);
      rd(8'h08, 32'h100, 32'h13f, 1'b0);
      chk("switch pins", {30'h0, sw_en, hiz}, 32'h2);
      chk("mode pins", {30'h0, forced_switching_mode, fwd}, 32'h2);
    end
    wait_st(3'd4);
    flt <= 6'h02;
    tick(60);
    flt <= 6'h0;
    tick(140);
    rd(8'h08, 32'h100, 32'h13f, 1'b0);
    psave <= 1'b1;
    flt <= 6'h10;
    tick(140);
    rd(8'h08, 32'h100, 32'h13f, 1'b0);
    psave <= 1'b0;
    flt <= 6'h0;
    d = $random(seed) & 32'hfffffffe;
    bus(1'b1, 8'h00, d, 1'b0, q);
    rd(8'h00, 32'h0, 32'h1, 1'b0);
    wait_st(3'd2);
    bus(1'b1, 8'h00, 32'h1, 1'b0, q);
    wait_st(3'd4);
    aux <= 1'b1;
    tick(200);
    chk("peak trim", {26'h0, trim}, 32'h3f);
    en_req <= 1'b0;
    wait_st(3'd0);
    code <= 4'h4;
    en_req <= 1'b1;
    wait_st(3'd4);
    tick(4500);
    chk("peak trim", {26'h0, trim}, 32'h0);
    aux <= 1'b0;
    tick(4500);
    chk("peak trim", {26'h0, trim}, 32'h3f);
    test_done();
  end
endmodule
`default_nettype wire
